// >>> rtl/rsw_status_words.sv
// Receive frame status word builder with AHB-Lite control and status registers.
`timescale 1ns/1ps
// How it works
// - Every stored received frame gets status words describing length, status, sum, tag, wake.
// - Word A bit 31 flags an IPv4 header checksum error, never for IPv6.
// - Word A bit 30 flags a TCP, UDP, ICMP or IGMP checksum error.
// - Word A bit 29 is one for IPv6, zero for IPv4, forced to zero for class 00.
// - Word A bits 28:27 give class: none, TCP, UDP, other IP.
// - Word A bit 26 set for exact address match, clear for hash-only pass.
// - Word A bit 25 set for the all-ones broadcast destination.
// - Word A bit 24 set when first destination byte lsb is one, not broadcast.
// - Word A bit 15 set for a unicast destination.
// - Word A bit 23 set when a VLAN tag was removed; tag goes to word B.
// - Word A bit 22 is the OR of all receive error flags.
// - Word A bit 21 set when the MAC truncated an over-long frame.
// - Word A bit 20 flags a frame shorter than 64 bytes or a short frame.
// - Word A bit 19 flags length above the configured maximum, without truncating.
// - Word A bit 18 set when the PHY receive error appeared during the frame.
// - Word A bit 17 flags a non-whole byte count with FCS error, not gigabit.
// - Word A bit 16 flags FCS mismatch and is also set on PHY receive error.
// - Word A bit 14 set when hardware could not compute the L4 checksum.
// - Word A bits 13:0 hold the length, four less but never below zero when FCS stripping is on.
// - Word B bits 31:16 hold the raw layer-3 checksum.
// - Word B bits 15:0 hold the extracted VLAN tag.
// - At frame end both words go into the two slots ahead of the frame data.
// - Word C bit 15 marks a wakeup frame, bit 14 a wakeup frame failing filters.
module rsw_status_words #(
  parameter int PTR_W = 12
) (
  // Clock and reset.
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave port.
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // End-of-frame status from the receive path.
  input  wire logic                 eof_valid,
  output logic                      eof_ready,
  input  wire rsw_pkg::rsw_status_t eof_status,
  input  wire logic [PTR_W-1:0]     eof_head_ptr,
  // Status word writes into the receive FIFO.
  output logic                      word_wr_valid,
  input  wire logic                 word_wr_ready,
  output logic      [PTR_W-1:0]     word_wr_addr,
  output logic      [31:0]          word_wr_data,
  output logic      [15:0]          word_c
);

  // ****************************************************************
  // Elaboration check.
  // ****************************************************************
  if (PTR_W < 2 || PTR_W > 30) begin : g_bad_ptr
    $error("PTR_W must lie between 2 and 30");
  end

  // ****************************************************************
  // Writer state machine and latched words.
  // ****************************************************************
  typedef enum logic [2:0] {
    RSW_IDLE = 3'b001,
    RSW_WR_A = 3'b010,
    RSW_WR_B = 3'b100
  } rsw_state_t;

  rsw_state_t             state_reg;
  rsw_state_t             state_next;
  logic [31:0]            word_a_reg;
  logic [31:0]            word_b_reg;
  logic [15:0]            word_c_reg;
  logic [PTR_W-1:0]       head_reg;
  logic [31:0]            ctrl_reg;
  logic [rsw_pkg::LEN_W-1:0] max_size_reg;
  logic [31:0]            frame_cnt_reg;

  // Handshake decode.
  wire accept_eof = eof_valid && eof_ready;
  wire wr_done    = word_wr_valid && word_wr_ready;
  wire fcs_strip  = ctrl_reg[rsw_pkg::CTRL_FCS_STRIP_BIT];

  // ****************************************************************
  // Field formation from the incoming status.
  // ****************************************************************
  wire [rsw_pkg::LEN_W-1:0] raw_len = eof_status.frame_byte_count;
  // A stripped length never wraps below zero on a damaged tiny frame.
  wire [rsw_pkg::LEN_W-1:0] stripped_len = (raw_len >= rsw_pkg::FCS_BYTES) ?
                                           raw_len - rsw_pkg::FCS_BYTES : '0;
  wire [rsw_pkg::LEN_W-1:0] len_field = fcs_strip ? stripped_len : raw_len;
  wire is_bcast   = &eof_status.dest_addr;
  wire group_bit  = eof_status.dest_addr[40];
  wire is_mcast   = group_bit && !is_bcast;
  wire is_ucast   = !group_bit;
  wire no_ip      = eof_status.protocol_class_code == rsw_pkg::RSW_CLASS_NONE_IP;
  wire ipv6       = eof_status.ip_version_six_flag && !no_ip;
  wire ip_hdr_err = eof_status.ip_header_sum_error && !ipv6 && !no_ip;
  wire l4_err     = eof_status.l4_checksum_error && !no_ip;
  wire phy_err    = eof_status.phy_receive_error_flag;
  wire runt       = eof_status.mac_runt || (raw_len < rsw_pkg::MIN_FRAME_BYTES);
  wire too_long   = raw_len > max_size_reg;
  wire wdog       = eof_status.watchdog_truncated_flag;
  wire align_err  = eof_status.dribble && eof_status.fcs_error &&
                    !eof_status.gigabit_mode;
  wire fcs_err    = eof_status.fcs_error || phy_err;
  wire err_sum    = fcs_err || align_err || phy_err || too_long ||
                    runt || wdog || ip_hdr_err || l4_err;

  // First word assembled field by field.
  logic [31:0] word_a_next;
  always_comb begin
    word_a_next                       = '0;
    word_a_next[rsw_pkg::A_IP_HDR_ERR] = ip_hdr_err;
    word_a_next[rsw_pkg::A_L4_ERR]    = l4_err;
    word_a_next[rsw_pkg::A_IPV6]      = ipv6;
    word_a_next[rsw_pkg::A_CLASS_HI:rsw_pkg::A_CLASS_LO] = eof_status.protocol_class_code;
    word_a_next[rsw_pkg::A_EXACT]     = eof_status.exact_match_passed;
    word_a_next[rsw_pkg::A_BCAST]     = is_bcast;
    word_a_next[rsw_pkg::A_MCAST]     = is_mcast;
    word_a_next[rsw_pkg::A_VLAN]      = eof_status.vlan_tagged_flag;
    word_a_next[rsw_pkg::A_ERR_SUM]   = err_sum;
    word_a_next[rsw_pkg::A_WDOG]      = wdog;
    word_a_next[rsw_pkg::A_RUNT]      = runt;
    word_a_next[rsw_pkg::A_LONG]      = too_long;
    word_a_next[rsw_pkg::A_PHY_ERR]   = phy_err;
    word_a_next[rsw_pkg::A_ALIGN]     = align_err;
    word_a_next[rsw_pkg::A_FCS]       = fcs_err;
    word_a_next[rsw_pkg::A_UNICAST]   = is_ucast;
    word_a_next[rsw_pkg::A_L4_SKIP]   = eof_status.l4_sum_skipped_flag;
    word_a_next[rsw_pkg::LEN_W-1:0]   = len_field;
  end

  // Second and third words.
  wire [31:0] word_b_next = {eof_status.raw_l3_sum, eof_status.vlan_tag_field};
  wire [15:0] word_c_next = {eof_status.wake_frame,
                             eof_status.filter_reject_flag && eof_status.wake_frame,
                             14'h0000};

  // ****************************************************************
  // Writer: latch at end of frame, then write A then B.
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RSW_IDLE: begin
        if (accept_eof) begin
          state_next = RSW_WR_A;
        end
      end
      RSW_WR_A: begin
        if (word_wr_ready) begin
          state_next = RSW_WR_B;
        end
      end
      RSW_WR_B: begin
        if (word_wr_ready) begin
          state_next = RSW_IDLE;
        end
      end
      default: begin
        state_next = RSW_IDLE;
      end
    endcase
  end

  // One frame in flight; the source waits until both words have been written.
  assign eof_ready     = (state_reg == RSW_IDLE);
  assign word_wr_valid = (state_reg == RSW_WR_A) || (state_reg == RSW_WR_B);
  assign word_wr_addr  = (state_reg == RSW_WR_B) ? head_reg + PTR_W'(1) : head_reg;
  assign word_wr_data  = (state_reg == RSW_WR_B) ? word_b_reg : word_a_reg;
  assign word_c        = word_c_reg;

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= RSW_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Capture of every input at the end of frame, all words in one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_a_reg <= '0;
      word_b_reg <= '0;
      word_c_reg <= '0;
      head_reg   <= '0;
    end else if (accept_eof) begin
      word_a_reg <= word_a_next;
      word_b_reg <= word_b_next;
      word_c_reg <= word_c_next;
      head_reg   <= eof_head_ptr;
    end
  end

  // Count of frames whose words have been fully written.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_cnt_reg <= '0;
    end else if (wr_done && state_reg == RSW_WR_B) begin
      frame_cnt_reg <= frame_cnt_reg + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // AHB-Lite slave: zero wait states, always OKAY.
  // ****************************************************************
  logic       wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;

  wire        addr_phase = hsel && htrans[1] && hready;
  wire [7:0]  addr_lo    = haddr[7:0];
  wire        wr_ctrl    = wr_pend_reg && wr_addr_reg == rsw_pkg::CTRL_OFFSET;
  wire        wr_max     = wr_pend_reg && wr_addr_reg == rsw_pkg::MAX_SIZE_OFFSET;
  // Unmapped addresses read zero; writes to them are dropped.
  wire [31:0] rd_mux =
    (addr_lo == rsw_pkg::CTRL_OFFSET)      ? ctrl_reg :
    (addr_lo == rsw_pkg::MAX_SIZE_OFFSET)  ? {18'h00000, max_size_reg} :
    (addr_lo == rsw_pkg::FRAME_CNT_OFFSET) ? frame_cnt_reg :
    (addr_lo == rsw_pkg::LAST_A_OFFSET)    ? word_a_reg :
    (addr_lo == rsw_pkg::LAST_B_OFFSET)    ? word_b_reg :
    (addr_lo == rsw_pkg::LAST_C_OFFSET)    ? {16'h0000, word_c_reg} : 32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // Address phase capture; read data is fetched at the address edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg  <= '0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= addr_lo;
      if (addr_phase && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // Writable registers; only the strip enable bit of control is kept.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= rsw_pkg::CTRL_RESET;
      max_size_reg <= rsw_pkg::MAX_SIZE_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {31'h0000_0000, hwdata[rsw_pkg::CTRL_FCS_STRIP_BIT]};
      end
      if (wr_max) begin
        max_size_reg <= hwdata[rsw_pkg::LEN_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Assertions and covers.
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ip_hdr;
    word_a_reg[rsw_pkg::A_IP_HDR_ERR] |-> !word_a_reg[rsw_pkg::A_IPV6];
  endproperty
  a_ip_hdr: assert property (p_ip_hdr) else $error("IP header error flagged on IPv6.");

  property p_ipv6_class;
    word_a_reg[rsw_pkg::A_CLASS_HI:rsw_pkg::A_CLASS_LO] == 2'b00 |-> !word_a_reg[rsw_pkg::A_IPV6];
  endproperty
  a_ipv6_class: assert property (p_ipv6_class) else $error("IPv6 flag set on non-IP frame.");

  property p_addr_type;
    word_a_reg[rsw_pkg::A_BCAST] |-> !word_a_reg[rsw_pkg::A_MCAST] && !word_a_reg[rsw_pkg::A_UNICAST];
  endproperty
  a_addr_type: assert property (p_addr_type) else $error("Broadcast frame also marked other type.");

  property p_mcast_ucast;
    word_a_reg[rsw_pkg::A_MCAST] |-> !word_a_reg[rsw_pkg::A_UNICAST];
  endproperty
  a_mcast_ucast: assert property (p_mcast_ucast) else $error("Multicast frame also marked unicast.");

  property p_phy_fcs;
    word_a_reg[rsw_pkg::A_PHY_ERR] |-> word_a_reg[rsw_pkg::A_FCS] && word_a_reg[rsw_pkg::A_ERR_SUM];
  endproperty
  a_phy_fcs: assert property (p_phy_fcs) else $error("PHY error without FCS and summary.");

  // The summary must name a cause, so a stuck summary bit is caught as well as a missing one.
  property p_err_sum;
    word_a_reg[rsw_pkg::A_ERR_SUM] == |{word_a_reg[rsw_pkg::A_IP_HDR_ERR:rsw_pkg::A_L4_ERR],
                                        word_a_reg[rsw_pkg::A_WDOG:rsw_pkg::A_FCS]};
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("Error summary does not match its causes.");

  // Length is held against the raw count only while stripping is off; the strip path has its own check below.
  property p_len;
    accept_eof && !fcs_strip |=> word_a_reg[rsw_pkg::LEN_W-1:0] == $past(eof_status.frame_byte_count);
  endproperty
  a_len: assert property (p_len) else $error("Length field wrong after capture.");

  property p_len_strip;
    accept_eof && fcs_strip && eof_status.frame_byte_count >= rsw_pkg::FCS_BYTES |=>
      word_a_reg[rsw_pkg::LEN_W-1:0] + rsw_pkg::FCS_BYTES == $past(eof_status.frame_byte_count);
  endproperty
  a_len_strip: assert property (p_len_strip) else $error("Stripped length not four below raw.");

  property p_vlan;
    accept_eof && eof_status.vlan_tagged_flag |=>
      word_a_reg[rsw_pkg::A_VLAN] && word_b_reg[15:0] == $past(eof_status.vlan_tag_field);
  endproperty
  a_vlan: assert property (p_vlan) else $error("VLAN tag not carried to word B.");

  property p_first_slot;
    accept_eof |=> word_wr_valid && word_wr_addr == $past(eof_head_ptr) && word_wr_data == word_a_reg;
  endproperty
  a_first_slot: assert property (p_first_slot) else $error("Word A not written to head slot.");

  property p_second_slot;
    wr_done && state_reg == RSW_WR_A |=>
      word_wr_valid && word_wr_addr == $past(word_wr_addr) + PTR_W'(1) && word_wr_data == word_b_reg;
  endproperty
  a_second_slot: assert property (p_second_slot) else $error("Word B not in following slot.");

  property p_wake;
    word_c[rsw_pkg::C_FILTER_FAIL] |-> word_c[rsw_pkg::C_WAKE];
  endproperty
  a_wake: assert property (p_wake) else $error("Filter fail without wakeup.");

  property p_busy;
    word_wr_valid |-> !eof_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("New frame taken while words pending.");

  c_frame: cover property (accept_eof ##1 wr_done ##1 wr_done);
  c_stall: cover property (word_wr_valid && !word_wr_ready ##1 wr_done);
  c_error: cover property (accept_eof ##1 word_a_reg[rsw_pkg::A_ERR_SUM]);
  c_strip: cover property (fcs_strip && accept_eof);

endmodule : rsw_status_words

// >>> rtl/rsw_pkg.sv
// Package with the constants and types of the receive frame status word block.
package rsw_pkg;

  // ****************************************************************
  // Register map of the AHB-Lite slave.
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET      = 8'h00;
  localparam logic [7:0] MAX_SIZE_OFFSET  = 8'h04;
  localparam logic [7:0] FRAME_CNT_OFFSET = 8'h08;
  localparam logic [7:0] LAST_A_OFFSET    = 8'h0C;
  localparam logic [7:0] LAST_B_OFFSET    = 8'h10;
  localparam logic [7:0] LAST_C_OFFSET    = 8'h14;

  // Control register fields and reset values.
  localparam int          CTRL_FCS_STRIP_BIT = 0;
  localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
  localparam logic [13:0] MAX_SIZE_RESET     = 14'h05EE;

  // ****************************************************************
  // Field positions of the first status word.
  // ****************************************************************
  localparam int A_IP_HDR_ERR  = 31;
  localparam int A_L4_ERR      = 30;
  localparam int A_IPV6        = 29;
  localparam int A_CLASS_HI    = 28;
  localparam int A_CLASS_LO    = 27;
  localparam int A_EXACT       = 26;
  localparam int A_BCAST       = 25;
  localparam int A_MCAST       = 24;
  localparam int A_VLAN        = 23;
  localparam int A_ERR_SUM     = 22;
  localparam int A_WDOG        = 21;
  localparam int A_RUNT        = 20;
  localparam int A_LONG        = 19;
  localparam int A_PHY_ERR     = 18;
  localparam int A_ALIGN       = 17;
  localparam int A_FCS         = 16;
  localparam int A_UNICAST     = 15;
  localparam int A_L4_SKIP     = 14;
  localparam int LEN_W         = 14;

  // Third word: wakeup flags, low bits reserved.
  localparam int C_WAKE        = 15;
  localparam int C_FILTER_FAIL = 14;

  // Frame size limits.
  localparam logic [LEN_W-1:0] MIN_FRAME_BYTES = 14'd64;
  localparam logic [LEN_W-1:0] FCS_BYTES       = 14'd4;

  // Protocol class encodings.
  typedef enum logic [1:0] {
    RSW_CLASS_NONE_IP = 2'b00,
    RSW_CLASS_TCP     = 2'b01,
    RSW_CLASS_UDP     = 2'b10,
    RSW_CLASS_IP      = 2'b11
  } rsw_class_t;

  // End-of-frame status gathered from the MAC, filter and checksum logic.
  typedef struct packed {
    logic [LEN_W-1:0] frame_byte_count;
    logic [47:0]      dest_addr;
    logic             exact_match_passed;
    logic             fcs_error;
    logic             dribble;
    logic             phy_receive_error_flag;
    logic             mac_runt;
    logic             watchdog_truncated_flag;
    logic             gigabit_mode;
    logic             ip_header_sum_error;
    logic             l4_checksum_error;
    logic             l4_sum_skipped_flag;
    logic             ip_version_six_flag;
    rsw_class_t       protocol_class_code;
    logic             vlan_tagged_flag;
    logic [15:0]      vlan_tag_field;
    logic [15:0]      raw_l3_sum;
    logic             wake_frame;
    logic             filter_reject_flag;
  } rsw_status_t;

endpackage : rsw_pkg

// >>> dv/rsw_fifo_model.sv
// Behavioural receive FIFO that takes status word writes, promptly or with stalls.
`timescale 1ns/1ps
module rsw_fifo_model #(
  parameter int PTR_W = 12
) (
  // Clock and reset.
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Pacing: high makes the FIFO take one word in four cycles.
  input  wire logic             slow,
  // Word write port.
  input  wire logic             word_wr_valid,
  output logic                  word_wr_ready,
  input  wire logic [PTR_W-1:0] word_wr_addr,
  input  wire logic [31:0]      word_wr_data,
  output int                    n_words
);
  logic [31:0] mem [2**PTR_W];
  logic [1:0]  pace_reg;

  // A stalling sink shows whether each word really stands until it is taken.
  assign word_wr_ready = !slow || (pace_reg == 2'h3);

  // Store every accepted word at its own address and count it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pace_reg <= 2'h0;
      n_words  <= 0;
    end else begin
      pace_reg <= pace_reg + 2'h1;
      if (word_wr_valid && word_wr_ready) begin
        mem[word_wr_addr] <= word_wr_data;
        n_words           <= n_words + 1;
      end
    end
  end
endmodule // rsw_fifo_model

// >>> dv/rx_frame_status_words_tb_top.sv
// Self-checking testbench of the receive frame status word builder.
`timescale 1ns/1ps
module rx_frame_status_words_tb_top;
  localparam logic [13:0] MAX_LEN = 14'h064;
  logic                 hclk, hresetn, hsel, hwrite, eof_valid, slow;
  logic [31:0]          haddr, hwdata, rd, b;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [11:0]          eof_head_ptr, head;
  rsw_pkg::rsw_status_t eof_status, st;
  wire logic [31:0]     hrdata, word_wr_data;
  wire logic            hready, hreadyout, hresp, eof_ready, word_wr_valid, word_wr_ready;
  wire logic [11:0]     word_wr_addr;
  wire logic [15:0]     word_c;
  int                   n_fail, checked, n_words;

  // One slave only, so its ready is the bus ready.
  assign hready = hreadyout;
  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;

  rsw_status_words uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .eof_valid(eof_valid), .eof_ready(eof_ready), .eof_status(eof_status),
    .eof_head_ptr(eof_head_ptr), .word_wr_valid(word_wr_valid), .word_wr_ready(word_wr_ready),
    .word_wr_addr(word_wr_addr), .word_wr_data(word_wr_data), .word_c(word_c));
  rsw_fifo_model fifo (.hclk(hclk), .hresetn(hresetn), .slow(slow), .word_wr_valid(word_wr_valid),
    .word_wr_ready(word_wr_ready), .word_wr_addr(word_wr_addr), .word_wr_data(word_wr_data), .n_words(n_words));

  // ****************************************************************
  // Compare, bus and frame tasks.
  // ****************************************************************
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; the master assumes no wait count.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do begin @(posedge hclk); end while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do begin @(posedge hclk); end while (hready !== 1'b1);
    rdat = hrdata;
    chk1(hresp, 1'b0);
  endtask

  // Offer one frame, then wait until both words have landed in the FIFO.
  task automatic send_frame(input rsw_pkg::rsw_status_t s, input logic [11:0] hd);
    int w0;
    w0 = n_words;
    eof_valid    <= 1'b1;
    eof_status   <= s;
    eof_head_ptr <= hd;
    do begin @(posedge hclk); end while (eof_ready !== 1'b1);
    // Released inputs change so a stale capture cannot pass.
    eof_valid    <= 1'b0;
    eof_status   <= ~s;
    eof_head_ptr <= ~hd;
    #1;
    chk1(word_wr_valid, 1'b1);
    chk1(eof_ready, 1'b0);
    while (n_words != w0 + 2) begin @(posedge hclk); end
    chk1(eof_ready, 1'b1);
  endtask

  // Expected first word, worked out from the field definitions.
  function automatic logic [31:0] exp_a(input rsw_pkg::rsw_status_t s, input logic strip);
    logic [31:0] a;
    logic        ip;
    logic        bc;
    a  = 32'h0000_0000;
    ip = s.protocol_class_code != rsw_pkg::RSW_CLASS_NONE_IP;
    bc = s.dest_addr == 48'hFFFF_FFFF_FFFF;
    a[31] = ip && !s.ip_version_six_flag && s.ip_header_sum_error;
    a[30] = ip && s.l4_checksum_error;
    a[29] = ip && s.ip_version_six_flag;
    a[28:27] = s.protocol_class_code;
    a[26] = s.exact_match_passed;
    a[25] = bc;
    a[24] = s.dest_addr[40] && !bc;
    a[23] = s.vlan_tagged_flag;
    a[21] = s.watchdog_truncated_flag;
    a[20] = s.mac_runt || s.frame_byte_count < 14'h040;
    a[19] = s.frame_byte_count > MAX_LEN;
    a[18] = s.phy_receive_error_flag;
    a[17] = s.dribble && s.fcs_error && !s.gigabit_mode;
    a[16] = s.fcs_error || s.phy_receive_error_flag;
    a[22] = |{a[31:30], a[21:16]};
    a[15] = !s.dest_addr[40];
    a[14] = s.l4_sum_skipped_flag;
    a[13:0] = !strip ? s.frame_byte_count : (s.frame_byte_count < 14'h4 ? 14'h0 : s.frame_byte_count - 14'h4);
    return a;
  endfunction

  task report_and_stop;
    $display("Counts: checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence and watchdog.
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    report_and_stop;
  end

  initial begin
    logic [13:0] lens [8];
    logic [7:0]  offs [4];
    logic [31:0] rv [4];
    logic [7:0]  v, e;
    lens = '{14'h003, 14'h03F, 14'h040, 14'h064, 14'h065, 14'h5EE, 14'h3FFF, 14'h0C8};
    offs = '{rsw_pkg::CTRL_OFFSET, rsw_pkg::MAX_SIZE_OFFSET, rsw_pkg::FRAME_CNT_OFFSET, 8'h40};
    rv   = '{32'h0000_0000, 32'h0000_05EE, 32'h0000_0000, 32'h0000_0000};
    {hresetn, hsel, hwrite, eof_valid, slow} = 5'h00;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    eof_status = '0;
    eof_head_ptr = 12'h000;
    n_fail = 0;
    checked = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, an ignored unmapped write, then a new size limit.
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
    for (int k = 0; k < 4; k++) begin
      ahb(1'b0, offs[k], 32'h0, rd);
      chk32(rd, rv[k]);
    end
    ahb(1'b1, rsw_pkg::MAX_SIZE_OFFSET, {18'h0, MAX_LEN}, rd);
    ahb(1'b0, rsw_pkg::MAX_SIZE_OFFSET, 32'h0, rd);
    chk32(rd, {18'h0, MAX_LEN});
    $display("test registers done");
    // Sixteen frames walk every class, address kind and error; FCS stripping from frame 8.
    for (int i = 0; i < 16; i++) begin
      if (i == 8) ahb(1'b1, rsw_pkg::CTRL_OFFSET, 32'h0000_0001, rd);
      v = 8'(i * 91) ^ 8'hA6;
      e = (i % 5 == 0) ? 8'h00 : v;
      st = '0;
      st.frame_byte_count = lens[i % 8];
      st.dest_addr = (i % 3 == 0) ? 48'hFFFF_FFFF_FFFF :
                     (i % 3 == 1) ? (48'h0100_5E00_0000 | 48'(i)) : (48'h0212_3400_0000 | 48'(i));
      {st.exact_match_passed, st.gigabit_mode, st.l4_sum_skipped_flag} = {v[0], v[7], v[1]};
      {st.fcs_error, st.dribble, st.phy_receive_error_flag} = {e[1], e[2], e[3]};
      {st.mac_runt, st.watchdog_truncated_flag, st.ip_header_sum_error} = {e[4] & e[5], e[6], e[0]};
      {st.l4_checksum_error, st.ip_version_six_flag, st.vlan_tagged_flag} = {e[5], v[4], v[5]};
      st.protocol_class_code = rsw_pkg::rsw_class_t'(2'(i) ^ 2'(i >> 2));
      st.vlan_tag_field = 16'hE000 | 16'(i);
      st.raw_l3_sum = 16'hC300 + 16'(i);
      {st.wake_frame, st.filter_reject_flag} = {v[2], v[3]};
      head = (i == 3) ? 12'hFFF : 12'(i * 16);
      slow <= i[0];
      send_frame(st, head);
      chk32(fifo.mem[head], exp_a(st, i >= 8));
      b = fifo.mem[head + 12'h1];
      chk32({b[31:16], st.vlan_tagged_flag ? b[15:0] : 16'h0000},
            {st.raw_l3_sum, st.vlan_tagged_flag ? st.vlan_tag_field : 16'h0000});
      chk32({16'h0000, word_c}, {16'h0000, st.wake_frame, st.wake_frame && st.filter_reject_flag, 14'h0});
      ahb(1'b0, rsw_pkg::LAST_A_OFFSET, 32'h0, rd);
      chk32(rd, exp_a(st, i >= 8));
      ahb(1'b0, rsw_pkg::FRAME_CNT_OFFSET, 32'h0, rd);
      chk32(rd, 32'(i + 1));
    end
    $display("test frames done");
    report_and_stop;
  end
endmodule // rx_frame_status_words_tb_top
